/* design/plc_input_command_decoder.sv */
// control input decoder: eight configurable inputs to device commands
// Behaviour
// - inputs ignored at local control location (LOC_LOCAL)
// - per-input inversion before decoding
// - eight inputs with default function order
// - suppression follows rising and falling edges
// - run level: rise starts, fall stops
// - start on rising edge only
// - stop on rise, flood after hold
// - flood inlet on rising edge
// - purge follows rising and falling edges
// - clear acknowledges error or aborts calibration
// - combined calibration depends on operating state
// - falling edge confirms external calibration
// - internal calibration on rising edge
// - external calibration on rising edge
// - run toggle depends on operating state
// - purge set and clear inputs
// - suppression set, cleared entering standby
// - probe mode switches sniff in standby
`timescale 1ns/1ps
`default_nettype none

module plc_input_command_decoder
  import plc_in_pkg::*;
#(
  parameter int unsigned N_IN        = NUM_INPUTS,
  parameter int unsigned TICK_PERIOD = TICK_CYCLES
) (
  input  wire logic                   i_clock,
  input  wire logic                   i_reset,
  input  wire logic [N_IN-1:0]        i_plc_in,
  input  wire logic [N_IN-1:0]        i_invert,
  input  wire logic [N_IN*FUNC_W-1:0] i_func_map,
  input  wire logic                   i_use_default_map,
  input  wire logic [1:0]             i_location,
  input  wire op_state_t              i_op_state,
  input  wire logic [HOLD_W-1:0]      i_flood_hold,
  output cmd_t                        o_cmd,
  output logic                        o_suppress,
  output logic                        o_purge,
  output logic                        o_sniff
);

  // default map and function fields are sized for eight inputs only
  if (N_IN != NUM_INPUTS) begin : g_bad_width
    $error("N_IN must be eight");
  end
  // a one-cycle period would hold the tick high forever
  if (TICK_PERIOD < 2) begin : g_bad_tick
    $error("TICK_PERIOD too small");
  end

  logic [N_IN-1:0]        sync1_q;
  logic [N_IN-1:0]        sync2_q;
  logic [N_IN-1:0]        prev_q;
  logic [N_IN-1:0]        level;
  logic [N_IN-1:0]        rise;
  logic [N_IN-1:0]        fall;
  logic                   enabled;
  logic [N_IN*FUNC_W-1:0] map;
  logic [31:0]            tick_cnt_q;
  logic                   tick;
  logic [HOLD_W-1:0]      hold_q [N_IN];
  logic [N_IN-1:0]        flood_done_q;
  logic [N_IN-1:0]        hold_exp;
  cmd_t                   cmd_d;
  cmd_t                   cmd_q;
  logic                   sup_set, sup_clr, pur_set, pur_clr, sn_set, sn_clr;
  logic                   suppress_q, purge_q, sniff_q;
  op_state_t              op_prev_q;
  logic                   to_standby;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= i_plc_in;
      sync2_q <= sync1_q;
    end
  end

  assign level = sync2_q ^ i_invert;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      prev_q <= '0;
    end else begin
      prev_q <= level;
    end
  end

  assign enabled = (i_location == LOC_EXTERNAL) || (i_location == LOC_LOCAL_EXT)
                   || (i_location == LOC_ALL);
  assign rise    = enabled ? (level & ~prev_q) : '0;
  assign fall    = enabled ? (~level & prev_q) : '0;

  assign map = i_use_default_map ? DEFAULT_MAP[N_IN*FUNC_W-1:0] : i_func_map;

  // millisecond time base for long holds
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end
  assign tick = (tick_cnt_q == 32'(TICK_PERIOD - 1));

  // flood hold timers, one per input
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < N_IN; k++) hold_q[k] <= '0;
      flood_done_q <= '0;
    end else begin
      for (int k = 0; k < N_IN; k++) begin
        if (!enabled || !level[k] || map[k*FUNC_W +: FUNC_W] != FN_STOP) begin
          hold_q[k]       <= '0;
          flood_done_q[k] <= 1'b0;
        end else if (hold_exp[k]) begin
          flood_done_q[k] <= 1'b1;
        end else if (tick && !flood_done_q[k]) begin
          hold_q[k] <= hold_q[k] + 16'h1;
        end
      end
    end
  end
  always_comb begin
    for (int k = 0; k < N_IN; k++)
      hold_exp[k] = !flood_done_q[k] && level[k] && enabled
                    && map[k*FUNC_W +: FUNC_W] == FN_STOP && hold_q[k] > i_flood_hold;
  end

  // per-input decoding of functions
  always_comb begin
    cmd_d   = '0;
    sup_set = 1'b0;
    sup_clr = 1'b0;
    pur_set = 1'b0;
    pur_clr = 1'b0;
    sn_set  = 1'b0;
    sn_clr  = 1'b0;
    for (int k = 0; k < N_IN; k++) begin
      case (map[k*FUNC_W +: FUNC_W])
        FN_START: if (rise[k]) cmd_d.start = 1'b1;
        FN_STOP: begin
          if (rise[k]) cmd_d.stop = 1'b1;
          if (hold_exp[k]) cmd_d.flood = 1'b1;
        end
        FN_SUPPRESS: begin
          if (rise[k]) sup_set = 1'b1;
          if (fall[k]) sup_clr = 1'b1;
        end
        FN_CAL: begin
          if (rise[k] && i_op_state == op_standby) cmd_d.cal_int = 1'b1;
          if (rise[k] && i_op_state == op_measure) cmd_d.cal_manual = 1'b1;
          if (fall[k] && i_op_state == op_adjust_ext) cmd_d.cal_confirm = 1'b1;
        end
        FN_CAL_INT: if (rise[k]) cmd_d.cal_int = 1'b1;
        FN_ADJUST_EXT: if (rise[k]) cmd_d.adjust_ext = 1'b1;
        FN_CLEAR: if (rise[k]) cmd_d.clear = 1'b1;
        FN_PURGE: begin
          if (rise[k]) pur_set = 1'b1;
          if (fall[k]) pur_clr = 1'b1;
        end
        FN_RUN_LEVEL: begin
          if (rise[k]) cmd_d.start = 1'b1;
          if (fall[k]) cmd_d.stop = 1'b1;
        end
        FN_FLOOD: if (rise[k]) cmd_d.flood = 1'b1;
        FN_RUN_TOGGLE: begin
          if (rise[k] && i_op_state == op_standby) cmd_d.start = 1'b1;
          if (rise[k] && i_op_state == op_measure) cmd_d.stop = 1'b1;
        end
        FN_PURGE_SET: if (rise[k]) pur_set = 1'b1;
        FN_PURGE_CLR: if (rise[k]) pur_clr = 1'b1;
        FN_SUPPRESS_ON: if (rise[k]) sup_set = 1'b1;
        FN_PROBE: begin
          if (rise[k] && i_op_state == op_standby) sn_set = 1'b1;
          if (fall[k] && i_op_state == op_standby) sn_clr = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      cmd_q <= '0;
    end else begin
      cmd_q <= cmd_d;
    end
  end
  assign o_cmd = cmd_q;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      op_prev_q <= op_standby;
    end else begin
      op_prev_q <= i_op_state;
    end
  end
  assign to_standby = (i_op_state == op_standby) && (op_prev_q != op_standby);

  // auto clear on standby; set wins
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      suppress_q <= 1'b0;
    end else if (sup_set) begin
      suppress_q <= 1'b1;
    end else if (sup_clr || to_standby) begin
      suppress_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      purge_q <= 1'b0;
    end else if (pur_set) begin
      purge_q <= 1'b1;
    end else if (pur_clr) begin
      purge_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sniff_q <= 1'b0;
    end else if (sn_set) begin
      sniff_q <= 1'b1;
    end else if (sn_clr) begin
      sniff_q <= 1'b0;
    end
  end

  assign o_suppress = suppress_q;
  assign o_purge    = purge_q;
  assign o_sniff    = sniff_q;

  // assertions
  // no command while gated off
  gate_off_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !enabled |=> (cmd_q == '0 || $past(hold_exp) != '0))
    else $error("command issued while control location local");
  // start issued the cycle after a rising edge on input 0 mapped to start
  start_pulse_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (map[3:0] == FN_START && $stable(map) && rise[0]) |=> o_cmd.start)
    else $error("start not issued after rising edge");
  edge_src_a: assert property (@(posedge i_clock) disable iff (i_reset)
    rise[0] |-> (level[0] && !prev_q[0]))
    else $error("rise without level change");
  sup_set_a: assert property (@(posedge i_clock) disable iff (i_reset)
    sup_set |=> o_suppress)
    else $error("suppression not set");
  sup_standby_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (to_standby && !sup_set) |=> !o_suppress)
    else $error("suppression kept on entering standby");
  purge_clr_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (pur_clr && !pur_set) |=> !o_purge)
    else $error("purge not cleared");
  sniff_state_a: assert property (@(posedge i_clock) disable iff (i_reset)
    $rose(o_sniff) |-> $past(i_op_state) == op_standby)
    else $error("sniff entered outside standby");
  cal_state_a: assert property (@(posedge i_clock) disable iff (i_reset)
    o_cmd.cal_manual |-> $past(i_op_state) == op_measure)
    else $error("manual calibration outside measurement");
  cal_conf_a: assert property (@(posedge i_clock) disable iff (i_reset)
    o_cmd.cal_confirm |-> $past(i_op_state) == op_adjust_ext)
    else $error("confirm outside external calibration");
  start_cov: cover property (@(posedge i_clock) disable iff (i_reset) o_cmd.start);
  flood_cov: cover property (@(posedge i_clock) disable iff (i_reset) o_cmd.flood);
  sniff_cov: cover property (@(posedge i_clock) disable iff (i_reset) $rose(o_sniff));

endmodule : plc_input_command_decoder

`default_nettype wire

/* design/plc_in_pkg.sv */
// package: function codes, defaults and timing for the control input decoder
package plc_in_pkg;

  localparam int unsigned NUM_INPUTS = 8;
  localparam int unsigned FUNC_W     = 4;

  // function codes per input
  localparam logic [3:0] FN_NONE        = 4'h0;
  localparam logic [3:0] FN_START       = 4'h1;
  localparam logic [3:0] FN_STOP        = 4'h2;
  localparam logic [3:0] FN_SUPPRESS    = 4'h3;
  localparam logic [3:0] FN_CAL         = 4'h4;
  localparam logic [3:0] FN_CAL_INT     = 4'h5;
  localparam logic [3:0] FN_ADJUST_EXT  = 4'h6;
  localparam logic [3:0] FN_CLEAR       = 4'h7;
  localparam logic [3:0] FN_PURGE       = 4'h8;
  localparam logic [3:0] FN_RUN_LEVEL   = 4'h9;
  localparam logic [3:0] FN_FLOOD       = 4'ha;
  localparam logic [3:0] FN_RUN_TOGGLE  = 4'hb;
  localparam logic [3:0] FN_PURGE_SET   = 4'hc;
  localparam logic [3:0] FN_PURGE_CLR   = 4'hd;
  localparam logic [3:0] FN_SUPPRESS_ON = 4'he;
  localparam logic [3:0] FN_PROBE       = 4'hf;

  // default assignment, input 0 in the low nibble
  localparam logic [31:0] DEFAULT_MAP = 32'h8765_4321;

  // control location codes
  localparam logic [1:0] LOC_LOCAL     = 2'h0;
  localparam logic [1:0] LOC_EXTERNAL  = 2'h1;
  localparam logic [1:0] LOC_LOCAL_EXT = 2'h2;
  localparam logic [1:0] LOC_ALL       = 2'h3;

  // operating state reported by the host controller
  typedef enum logic [1:0] {
    op_standby,
    op_measure,
    op_adjust_ext,
    op_other
  } op_state_t;

  // hold counter width for the flood delay, in enable ticks
  localparam int unsigned HOLD_W       = 16;
  // time base: one tick per millisecond
  localparam int unsigned TICK_MS      = 1;
  localparam int unsigned CLOCK_MHZ    = 200;
  localparam int unsigned TICK_CYCLES  = TICK_MS * CLOCK_MHZ * 1000;

  // command pulses issued to the host
  typedef struct packed {
    logic start;
    logic stop;
    logic flood;
    logic clear;
    logic cal_int;
    logic cal_manual;
    logic adjust_ext;
    logic cal_confirm;
  } cmd_t;

endpackage : plc_in_pkg

/* test/plc_model.sv */
// controller model driving the eight digital input lines
`timescale 1ns/1ps
`default_nettype none

module plc_model (
  input  wire logic       i_clock,
  output var  logic [7:0] o_lines
);
  // lines always driven, never released
  initial o_lines = 8'h00;

  // cal lines moved only at test-leak safe points
  // lines move only on a falling edge, well away from the sampling edge
  task automatic set_line(input int k, input logic v);
    @(negedge i_clock);
    o_lines[k] = v;
  endtask : set_line
endmodule : plc_model

`default_nettype wire

/* test/tb_top.sv */
// testbench: decoder against a behavioural model of the command rules
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import plc_in_pkg::*;
;
  logic        i_clock;
  logic        i_reset;
  wire  [7:0]  plc_lines;
  logic [7:0]  inv;
  logic [31:0] fmap;
  logic        use_def;
  logic [1:0]  loc;
  op_state_t   st;
  logic [15:0] hold;
  cmd_t        cmd;
  logic        sup_o;
  logic        pur_o;
  logic        snf_o;
  int          error_cnt;
  int          cmp_count;
  logic [7:0]  eff;
  logic        m_sup;
  logic        m_pur;
  logic        m_snf;
  logic [3:0]  dmap [8] = '{FN_START, FN_STOP, FN_SUPPRESS, FN_CAL,
                            FN_CAL_INT, FN_ADJUST_EXT, FN_CLEAR, FN_PURGE};

  plc_model plc_model_inst (.i_clock(i_clock), .o_lines(plc_lines));

  // short tick so the flood hold fits a short run
  plc_input_command_decoder #(.N_IN(8), .TICK_PERIOD(4)) plc_input_command_decoder_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_plc_in(plc_lines), .i_invert(inv),
    .i_func_map(fmap), .i_use_default_map(use_def), .i_location(loc), .i_op_state(st),
    .i_flood_hold(hold), .o_cmd(cmd), .o_suppress(sup_o), .o_purge(pur_o), .o_sniff(snf_o));

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic cmd_t model(input logic [3:0] fn, input bit rise, input op_state_t s);
    cmd_t c;
    c = '0;
    case (fn)
      FN_START:       c.start = rise;
      FN_STOP:        c.stop = rise;
      FN_RUN_LEVEL:   begin c.start = rise; c.stop = !rise; end
      FN_FLOOD:       c.flood = rise;
      FN_CLEAR:       c.clear = rise;
      FN_CAL_INT:     c.cal_int = rise;
      FN_ADJUST_EXT:  c.adjust_ext = rise;
      FN_CAL: begin
        c.cal_int = rise && s == op_standby;
        c.cal_manual = rise && s == op_measure;
        c.cal_confirm = !rise && s == op_adjust_ext;
      end
      FN_RUN_TOGGLE:  begin c.start = rise && s == op_standby; c.stop = rise && s == op_measure; end
      FN_SUPPRESS:    m_sup = rise;
      FN_SUPPRESS_ON: if (rise) m_sup = 1'b1;
      FN_PURGE:       m_pur = rise;
      FN_PURGE_SET:   if (rise) m_pur = 1'b1;
      FN_PURGE_CLR:   if (rise) m_pur = 1'b0;
      FN_PROBE:       if (s == op_standby) m_snf = rise;
      default: ;
    endcase
    return c;
  endfunction : model

  // one edge on input k, by line or by inversion, then an 8-cycle look
  task automatic step(input int k, input bit flip_inv, input logic [1:0] l, input op_state_t s);
    logic [7:0] ne;
    cmd_t       e;
    cmd_t       acc;
    int         n;
    logic [3:0] fn;
    @(negedge i_clock);
    loc = l;
    if (s == op_standby && st != op_standby) m_sup = 1'b0;
    st = s;
    if (flip_inv) inv[k] = ~inv[k];
    else plc_model_inst.set_line(k, ~plc_model_inst.o_lines[k]);
    ne = plc_model_inst.o_lines ^ inv;
    fn = use_def ? dmap[k] : fmap[4*k +: 4];
    e = '0;
    if (ne[k] != eff[k] && l != LOC_LOCAL) e = model(fn, ne[k], s);
    eff = ne;
    acc = '0;
    n = 0;
    repeat (8) begin
      @(posedge i_clock);
      #1;
      acc = acc | cmd;
      if (cmd !== '0) n++;
    end
    check("cmd", acc, e);
    check("pulses", 8'(n), {7'h00, e != '0});
    check("levels", {5'h00, sup_o, pur_o, snf_o}, {5'h00, m_sup, m_pur, m_snf});
  endtask : step

  initial begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    close_out();
  end

  initial begin
    cmd_t acc;
    int   nf;
    logic [3:0] c;
    i_reset = 1'b1;
    inv = 8'h00;
    fmap = 32'h0000_0000;
    use_def = 1'b1;
    loc = LOC_LOCAL;
    st = op_standby;
    hold = 16'h0003;
    error_cnt = 0;
    cmp_count = 0;
    eff = 8'h00;
    m_sup = 1'b0;
    m_pur = 1'b0;
    m_snf = 1'b0;
    void'($urandom(32'hd93e));
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    i_reset = 1'b0;
    // default map, map input ignored
    fmap = $urandom;
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 8; k++) begin
        step(k, 0, 2'(1 + s), op_state_t'(s));
        step(k, 0, 2'(1 + s), op_state_t'(s));
      end
    end
    // held stop floods once after the hold time
    step(1, 0, LOC_EXTERNAL, op_measure);
    acc = '0;
    nf = 0;
    repeat (40) begin
      @(posedge i_clock);
      #1;
      acc = acc | cmd;
      if (cmd.flood === 1'b1) nf++;
    end
    check("flood", 8'(nf), 8'h01);
    check("hold_cmd", acc, 8'h20);
    step(1, 0, LOC_EXTERNAL, op_measure);
    // random maps, states, locations; stop left out to keep flood timing out
    @(negedge i_clock);
    use_def = 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(negedge i_clock);
      for (int j = 0; j < 8; j++) begin
        c = 4'($urandom % 16);
        fmap[4*j +: 4] = (c == FN_STOP) ? FN_FLOOD : c;
      end
      step(int'($urandom % 8), 1'($urandom % 2), 2'($urandom % 4), op_state_t'($urandom % 4));
    end
    close_out();
  end
endmodule : tb_top

`default_nettype wire
